/* bench/matrix_mixer_router_bench.sv */
// self-checking bench for the matrix mixer router
`timescale 1ns/1ps
`default_nettype none
module matrix_mixer_router_bench;
    import mixer_pkg::*;
    logic mclk = 1'b0, resetn = 1'b0, frame_start = 1'b0, src_valid = 1'b0, hold = 1'b0;
    logic route_we = 1'b0, out_we = 1'b0, loop_we = 1'b0, loop_on = 1'b0;
    logic meter_clear = 1'b0, midi_rx_valid = 1'b0, select_button = 1'b0;
    logic stream_embedded_midi_tx_valid = 1'b0;
    logic [6:0] src_chan = 7'h00;
    logic [7:0] meter_sel = 8'h01;
    logic [5:0] loop_chan = 6'h00;
    logic [7:0] midi_rx_byte = 8'h00, stream_embedded_midi_tx = 8'h00;
    logic [SAMPLE_W-1:0] src_data = 24'h000000;
    route_wr_t route_wr = '0;
    out_wr_t out_wr = '0;
    logic out_valid, out_ready, busy, rec_valid, midi_tx_valid, input_optical;
    logic stream_embedded_midi_rx_valid, stream_embedded_midi_tx_ready;
    logic [7:0] stream_embedded_midi_rx, midi_tx_byte;
    logic [SAMPLE_W-1:0] meter_peak, meter_rms;
    sample_t out_sample, rec_sample;
    int n_errors = 0, cmp_count = 0;
    matrix_mixer_router #(.DEBOUNCE(4)) dut (
        .mclk, .resetn, .frame_start, .src_valid, .src_chan, .src_data, .route_we,
        .route_wr, .out_we, .out_wr, .loop_we, .loop_chan, .loop_on, .out_valid,
        .out_ready, .out_sample, .busy, .rec_sample, .rec_valid, .meter_sel,
        .meter_peak, .meter_rms, .meter_clear, .midi_rx_valid, .midi_rx_byte,
        .stream_embedded_midi_rx_valid, .stream_embedded_midi_rx,
        .stream_embedded_midi_tx_valid, .stream_embedded_midi_tx,
        .stream_embedded_midi_tx_ready, .midi_tx_valid, .midi_tx_byte,
        .select_button, .input_optical
    );
    sample_sink sink (.mclk, .hold, .out_valid, .out_ready, .out_sample);
    always #12.5 mclk = ~mclk;
    task automatic final_report;
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report
    task automatic check(input logic [SAMPLE_W-1:0] seen, input logic [SAMPLE_W-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n = 1);
        repeat (n) @(negedge mclk);
    endtask : tick
    task automatic route(input int s, input int d, input logic [GAIN_W-1:0] g);
        route_we = 1'b1;
        route_wr = '{src: s[6:0], dst: d[5:0], gain: g};
        tick();
    endtask : route
    task automatic feed(input int s, input logic [SAMPLE_W-1:0] v);
        src_valid = 1'b1;
        src_chan = s[6:0];
        src_data = v;
        tick();
    endtask : feed
    function automatic logic [SAMPLE_W-1:0] src_val(input int s);
        case (s)
            0: return 24'h001000;
            1, 2: return 24'h7fffff;
            5: return 24'h000400;
            64: return 24'h000200;
            70: return 24'hfff000;
            default: return 24'h000000;
        endcase
    endfunction : src_val
    function automatic logic [SAMPLE_W-1:0] mix_val(input int d);
        case (d)
            0: return 24'h001200;
            1: return 24'h000800;
            2: return 24'h000200;
            3: return 24'h7fffff;
            4: return 24'hfff000;
            default: return 24'h000000;
        endcase
    endfunction : mix_val
    // gain memories come up unknown, so every route is written before use
    task automatic t_setup;
        for (int s = 0; s < NUM_SRC; s++) begin
            for (int d = 0; d < NUM_CH; d++) begin
                route(s, d, GAIN_MUTE);
            end
        end
        route(0, 0, GAIN_UNITY);
        route(64, 0, GAIN_UNITY);
        route(0, 1, 16'h4000);
        route(5, 2, GAIN_UNITY);
        route(1, 3, GAIN_UNITY);
        route(2, 3, GAIN_UNITY);
        route(70, 4, GAIN_UNITY);
        route_we = 1'b0;
        out_we = 1'b1;
        for (int d = 0; d < NUM_CH; d++) begin
            out_wr = '{dst: d[5:0], gain: (d == 2) ? 16'h4000 : GAIN_UNITY};
            tick();
        end
        out_we = 1'b0;
        // meter memories come up unknown too, so clear every entry first
        meter_clear = 1'b1;
        for (int i = 0; i < NUM_SRC + NUM_CH; i++) begin
            meter_sel = i[7:0];
            tick();
        end
        meter_clear = 1'b0;
        meter_sel = 8'h01;
        for (int s = 0; s < NUM_SRC; s++) begin
            feed(s, src_val(s));
        end
        src_valid = 1'b0;
    endtask : t_setup
    task automatic t_meter;
        tick();
        check(meter_peak, 24'h7fffff);
        check(meter_rms, 24'h7fffff >> RMS_SHIFT);
        meter_sel = 8'h46;
        tick(2);
        check(meter_peak, 24'h001000);
        meter_sel = 8'h05;
        tick(2);
        check(meter_peak, 24'h000400);
        meter_clear = 1'b1;
        tick();
        meter_clear = 1'b0;
        tick(2);
        check(meter_peak, 24'h000000);
    endtask : t_meter
    task automatic t_mix;
        int k;
        hold = 1'b1;
        stream_embedded_midi_tx_valid = 1'b1;
        stream_embedded_midi_tx = 8'h5a;
        frame_start = 1'b1;
        tick();
        frame_start = 1'b0;
        stream_embedded_midi_tx_valid = 1'b0;
        check(midi_tx_valid, 1'b1);
        check(midi_tx_byte, 8'h5a);
        check(busy, 1'b1);
        frame_start = 1'b1;
        tick();
        frame_start = 1'b0;
        tick(6000);
        check(sink.n_got, 0);
        check(out_valid, 1'b1);
        hold = 1'b0;
        for (k = 0; k < 20000 && !(sink.n_got == 64 && busy === 1'b0); k++) begin
            tick();
        end
        if (k == 20000) begin
            n_errors++;
            final_report();
        end
        tick(300);
        check(sink.n_got, 64);
        for (int d = 0; d < NUM_CH; d++) begin
            check(sink.got[d], mix_val(d));
        end
        meter_sel = 8'h83;
        tick(2);
        check(meter_peak, 24'h7fffff);
        meter_sel = 8'h84;
        tick(2);
        check(meter_peak, 24'h001000);
    endtask : t_mix
    task automatic t_rec;
        feed(3, 24'h00abcd);
        check(rec_valid, 1'b1);
        check(rec_sample.chan, 6'h03);
        check(rec_sample.data, 24'h00abcd);
        feed(64, 24'h000777);
        check(rec_valid, 1'b0);
        src_valid = 1'b0;
        loop_we = 1'b1;
        loop_on = 1'b1;
        tick();
        loop_we = 1'b0;
        feed(0, 24'h000123);
        check(rec_valid, 1'b1);
        check(rec_sample.data, 24'h001200);
        src_valid = 1'b0;
        loop_we = 1'b1;
        loop_on = 1'b0;
        tick();
        loop_we = 1'b0;
        feed(0, 24'h000123);
        check(rec_sample.data, 24'h000123);
        src_valid = 1'b0;
    endtask : t_rec
    task automatic t_misc;
        midi_rx_valid = 1'b1;
        midi_rx_byte = 8'ha5;
        tick();
        midi_rx_valid = 1'b0;
        check(stream_embedded_midi_rx_valid, 1'b1);
        check(stream_embedded_midi_rx, 8'ha5);
        for (int i = 0; i < 2; i++) begin
            select_button = 1'b1;
            tick(12);
            select_button = 1'b0;
            tick(12);
            check(input_optical, (i == 0) ? 1'b1 : 1'b0);
        end
    endtask : t_misc
    initial begin
        tick(3);
        resetn = 1'b1;
        check(busy, 1'b0);
        check(out_valid, 1'b0);
        check(input_optical, 1'b0);
        t_setup();
        t_meter();
        t_mix();
        t_rec();
        t_misc();
        final_report();
    end
endmodule : matrix_mixer_router_bench
bind matrix_mixer_router mixer_assertions u_chk (
    .mclk, .resetn, .frame_start, .src_valid, .src_chan, .out_valid, .out_ready,
    .out_sample, .busy, .rec_valid, .midi_rx_valid, .midi_rx_byte,
    .stream_embedded_midi_rx_valid, .stream_embedded_midi_rx,
    .stream_embedded_midi_tx_valid, .stream_embedded_midi_tx,
    .stream_embedded_midi_tx_ready, .midi_tx_valid, .midi_tx_byte,
    .select_button, .input_optical
);
`default_nettype wire

/* bench/mixer_assertions.sv */
// port-level checks for the matrix mixer
`timescale 1ns/1ps
`default_nettype none
module mixer_assertions
    import mixer_pkg::*;
(
    input wire logic       mclk,
    input wire logic       resetn,
    input wire logic       frame_start,
    input wire logic       src_valid,
    input wire logic [6:0] src_chan,
    input wire logic       out_valid,
    input wire logic       out_ready,
    input wire sample_t    out_sample,
    input wire logic       busy,
    input wire logic       rec_valid,
    input wire logic       midi_rx_valid,
    input wire logic [7:0] midi_rx_byte,
    input wire logic       stream_embedded_midi_rx_valid,
    input wire logic [7:0] stream_embedded_midi_rx,
    input wire logic       stream_embedded_midi_tx_valid,
    input wire logic [7:0] stream_embedded_midi_tx,
    input wire logic       stream_embedded_midi_tx_ready,
    input wire logic       midi_tx_valid,
    input wire logic [7:0] midi_tx_byte,
    input wire logic       select_button,
    input wire logic       input_optical
);
    wire logic hw_in = src_valid && !src_chan[6];
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    property p_rec; hw_in |=> rec_valid; endproperty
    a_rec: assert property (p_rec) else $error("record sample missing");
    property p_rec_src; rec_valid |-> $past(hw_in); endproperty
    a_rec_src: assert property (p_rec_src) else $error("record without input");
    property p_mrx;
        midi_rx_valid |=> stream_embedded_midi_rx_valid
            && stream_embedded_midi_rx == $past(midi_rx_byte);
    endproperty
    a_mrx: assert property (p_mrx) else $error("midi rx byte lost");
    property p_mrdy; stream_embedded_midi_tx_ready == frame_start; endproperty
    a_mrdy: assert property (p_mrdy) else $error("midi tx ready off frame");
    property p_mtx;
        stream_embedded_midi_tx_valid && stream_embedded_midi_tx_ready
            |=> midi_tx_valid && midi_tx_byte == $past(stream_embedded_midi_tx);
    endproperty
    a_mtx: assert property (p_mtx) else $error("midi tx byte lost");
    property p_busy; frame_start && !busy |=> busy [*8]; endproperty
    a_busy: assert property (p_busy) else $error("pass did not start");
    property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_sample); endproperty
    a_hold: assert property (p_hold) else $error("output dropped while stalled");
    // a press just before release may still toggle through the synchroniser, so allow eight idle cycles
    property p_sel; !select_button [*8] |=> $stable(input_optical); endproperty
    a_sel: assert property (p_sel) else $error("input changed without press");
    c_pass: cover property (frame_start && !busy);
    c_stall: cover property (out_valid && !out_ready);
    c_tog: cover property ($changed(input_optical));
endmodule : mixer_assertions
`default_nettype wire

/* bench/sample_sink.sv */
// output sink that stalls and records every mixed sample
`timescale 1ns/1ps
`default_nettype none
module sample_sink
    import mixer_pkg::*;
(
    input wire logic    mclk,
    input wire logic    hold,
    input wire logic    out_valid,
    output logic        out_ready,
    input wire sample_t out_sample
);
    logic [SAMPLE_W-1:0] got [NUM_CH];
    int                  n_got = 0;
    logic [1:0]          cnt = 2'h0;
    initial out_ready = 1'b0;
    // one cycle in four is refused so the fifo sees back pressure
    always @(negedge mclk) begin
        cnt <= cnt + 2'h1;
        out_ready <= !hold && cnt != 2'h0;
    end
    always @(posedge mclk) begin
        if (out_valid && out_ready) begin
            got[out_sample.chan] <= out_sample.data;
            n_got <= n_got + 1;
        end
    end
endmodule : sample_sink
`default_nettype wire

/* logic/matrix_mixer_router.sv */
// matrix mixer, router, metering, embedded midi and input selector
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - 64 hardware inputs, 64 playback channels and 64 outputs.
// - any input or playback channel can be summed into any output.
// - each source-to-output route keeps its own independent gain.
// - record path carries inputs unchanged unless loopback is on.
// - input and playback meters are taken before route gain.
// - output meters are taken after mixing and output level.
// - peak and rms for sources, peak only for outputs.
// - each output has a level gain applied to its sum.
// - one midi byte stream in and out carried inside the audio stream.
// - button press toggles coaxial/optical input; indicator shows selection.
// - loopback feeds the last finished mix of an output to its record channel on that channel's next input sample.
// - peak meter has zero attack; one sample sets the reading.
module matrix_mixer_router
    import mixer_pkg::*;
#(
    parameter int DEBOUNCE = DEBOUNCE_CYC
) (
    input  wire logic                  mclk,
    input  wire logic                  resetn,
    input  wire logic                  frame_start,
    input  wire logic                  src_valid,
    input  wire logic [6:0]            src_chan,
    input  wire logic [SAMPLE_W-1:0]   src_data,
    input  wire logic                  route_we,
    input  wire route_wr_t             route_wr,
    input  wire logic                  out_we,
    input  wire out_wr_t               out_wr,
    input  wire logic                  loop_we,
    input  wire logic [5:0]            loop_chan,
    input  wire logic                  loop_on,
    output logic                       out_valid,
    input  wire logic                  out_ready,
    output sample_t                    out_sample,
    output logic                       busy,
    output sample_t                    rec_sample,
    output logic                       rec_valid,
    input  wire logic [7:0]            meter_sel,
    output logic      [SAMPLE_W-1:0]   meter_peak,
    output logic      [SAMPLE_W-1:0]   meter_rms,
    input  wire logic                  meter_clear,
    input  wire logic                  midi_rx_valid,
    input  wire logic [7:0]            midi_rx_byte,
    output logic                       stream_embedded_midi_rx_valid,
    output logic      [7:0]            stream_embedded_midi_rx,
    input  wire logic                  stream_embedded_midi_tx_valid,
    input  wire logic [7:0]            stream_embedded_midi_tx,
    output logic                       stream_embedded_midi_tx_ready,
    output logic                       midi_tx_valid,
    output logic      [7:0]            midi_tx_byte,
    input  wire logic                  select_button,
    output logic                       input_optical
);
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_SUM  = 2'b01,
        S_OUT  = 2'b10,
        S_PUSH = 2'b11
    } mix_state_t;

    localparam logic [ACC_W-1:0] SAT_MAX = ACC_W'({1'b0, {(SAMPLE_W-1){1'b1}}});
    localparam int DB_W = $clog2(DEBOUNCE + 1);

    logic signed [SAMPLE_W-1:0] samp_mem [NUM_SRC];   // latest sample per source
    logic        [GAIN_W-1:0]   gain_mem [NUM_SRC * NUM_CH];
    logic        [GAIN_W-1:0]   lvl_mem  [NUM_CH];
    logic        [SAMPLE_W-1:0] peak_mem [NUM_SRC + NUM_CH];
    logic        [SAMPLE_W-1:0] rms_mem  [NUM_SRC];
    logic        [NUM_CH-1:0]   loop_reg;
    logic signed [SAMPLE_W-1:0] mix_mem  [NUM_CH];

    mix_state_t                 state_reg;
    logic        [5:0]          dst_reg;
    logic        [6:0]          src_reg;
    logic signed [ACC_W-1:0]    acc_reg;
    logic signed [SAMPLE_W-1:0] result_reg;

    // ---- configuration stores
    always_ff @(posedge mclk) begin
        if (route_we) begin
            gain_mem[{route_wr.src, route_wr.dst}] <= route_wr.gain;
        end
        if (out_we) begin
            lvl_mem[out_wr.dst] <= out_wr.gain;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            loop_reg <= '0;
        end else if (loop_we) begin
            loop_reg[loop_chan] <= loop_on;
        end
    end

    // ---- source capture and record path
    always_ff @(posedge mclk) begin
        if (src_valid) begin
            samp_mem[src_chan] <= src_data;
        end
    end

    // record channel comes from the input, or from the last mix of that output on loopback
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rec_valid  <= 1'b0;
            rec_sample <= '0;
        end else begin
            rec_valid <= src_valid && !src_chan[6];
            if (src_valid && !src_chan[6]) begin
                rec_sample.chan <= src_chan[5:0];
                rec_sample.data <= loop_reg[src_chan[5:0]] ? mix_mem[src_chan[5:0]]
                                                            : src_data;
            end
        end
    end

    // ---- mixing engine: one multiply-accumulate per cycle
    function automatic logic signed [ACC_W-1:0] saturate(input logic signed [ACC_W-1:0] v);
        if (v > $signed(SAT_MAX)) begin
            return $signed(SAT_MAX);
        end else if (v < -$signed(SAT_MAX) - 1) begin
            return -$signed(SAT_MAX) - 1;
        end
        return v;
    endfunction : saturate

    logic [GAIN_W-1:0]        cur_gain;
    logic signed [ACC_W-1:0]  product;
    logic signed [ACC_W-1:0]  scaled;
    always_comb begin
        cur_gain = gain_mem[{src_reg, dst_reg}];
        // widen both factors first so the product is not cut to the sample width
        product  = (ACC_W'(samp_mem[src_reg]) * ACC_W'($signed({1'b0, cur_gain}))) >>> GAIN_FRAC;
        scaled   = ACC_W'(saturate(acc_reg) * $signed({1'b0, lvl_mem[dst_reg]})) >>> GAIN_FRAC;
    end

    logic fifo_in_ready;
    logic fifo_push;
    assign fifo_push = (state_reg == S_PUSH);
    assign busy      = (state_reg != S_IDLE);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_reg  <= S_IDLE;
            dst_reg    <= '0;
            src_reg    <= '0;
            acc_reg    <= '0;
            result_reg <= '0;
        end else begin
            unique case (state_reg)
                S_IDLE: begin
                    if (frame_start) begin
                        dst_reg   <= '0;
                        src_reg   <= '0;
                        acc_reg   <= '0;
                        state_reg <= S_SUM;
                    end
                end
                S_SUM: begin
                    if (cur_gain != GAIN_MUTE) begin
                        acc_reg <= saturate(acc_reg + product);
                    end
                    src_reg <= src_reg + 1'b1;
                    if (src_reg == 7'(NUM_SRC - 1)) begin
                        state_reg <= S_OUT;
                    end
                end
                S_OUT: begin
                    result_reg <= SAMPLE_W'(saturate(scaled));
                    state_reg  <= S_PUSH;
                end
                S_PUSH: begin
                    // stalls here while the output fifo is full
                    if (fifo_in_ready) begin
                        acc_reg <= '0;
                        dst_reg <= dst_reg + 1'b1;
                        state_reg <= (dst_reg == 6'(NUM_CH - 1)) ? S_IDLE : S_SUM;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (fifo_push && fifo_in_ready) begin
            mix_mem[dst_reg] <= result_reg;
        end
    end

    sample_fifo #(
        .WIDTH ($bits(sample_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_out_fifo (
        .mclk      (mclk),
        .resetn    (resetn),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .in_data   ({dst_reg, result_reg}),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_sample)
    );

    // ---- metering
    function automatic logic [SAMPLE_W-1:0] mag(input logic signed [SAMPLE_W-1:0] v);
        return v[SAMPLE_W-1] ? SAMPLE_W'(-v) : v;
    endfunction : mag

    logic [SAMPLE_W-1:0] src_mag;
    logic [SAMPLE_W-1:0] out_mag;
    logic [SAMPLE_W-1:0] rms_old;
    logic [SAMPLE_W-1:0] rms_new;
    assign src_mag = mag(src_data);   // pre-fader
    assign out_mag = mag(result_reg); // post mix and level
    assign rms_old = rms_mem[src_chan];
    // first-order mean of magnitude; slow time constant, cheap instead of a true square root
    assign rms_new = rms_old - (rms_old >> RMS_SHIFT) + (src_mag >> RMS_SHIFT);

    always_ff @(posedge mclk) begin
        if (meter_clear) begin
            peak_mem[meter_sel] <= '0;
        end else if (src_valid && src_mag > peak_mem[src_chan]) begin
            peak_mem[src_chan] <= src_mag;
        end
        if (fifo_push && fifo_in_ready && out_mag > peak_mem[NUM_SRC + dst_reg]) begin
            peak_mem[NUM_SRC + dst_reg] <= out_mag;
        end
        // clear also seeds the rms memory, which has no reset of its own
        if (meter_clear && !meter_sel[7]) begin
            rms_mem[meter_sel[6:0]] <= '0;
        end else if (src_valid) begin
            rms_mem[src_chan] <= rms_new;
        end
    end

    // meter_sel 0..127 sources, 128..191 output peaks; outputs have no rms
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            meter_peak <= '0;
            meter_rms  <= '0;
        end else begin
            meter_peak <= peak_mem[meter_sel];
            meter_rms  <= meter_sel[7] ? '0 : rms_mem[meter_sel[6:0]];
        end
    end

    // ---- embedded midi
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            stream_embedded_midi_rx_valid <= 1'b0;
            stream_embedded_midi_rx       <= '0;
            midi_tx_valid                 <= 1'b0;
            midi_tx_byte                  <= '0;
        end else begin
            stream_embedded_midi_rx_valid <= midi_rx_valid;
            if (midi_rx_valid) begin
                stream_embedded_midi_rx <= midi_rx_byte;
            end
            // one byte per frame slot, sent at frame start
            if (frame_start) begin
                midi_tx_valid <= stream_embedded_midi_tx_valid;
                midi_tx_byte  <= stream_embedded_midi_tx;
            end else begin
                midi_tx_valid <= 1'b0;
            end
        end
    end
    assign stream_embedded_midi_tx_ready = frame_start;

    // ---- input selector button
    logic            btn_s1_reg;
    logic            btn_s2_reg;
    logic            btn_stable_reg;
    logic [DB_W-1:0] db_cnt_reg;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            btn_s1_reg <= 1'b0;
            btn_s2_reg <= 1'b0;
        end else begin
            btn_s1_reg <= select_button;
            btn_s2_reg <= btn_s1_reg;
        end
    end

    // debounce so contact bounce cannot toggle twice
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            btn_stable_reg <= 1'b0;
            db_cnt_reg     <= '0;
            input_optical  <= 1'b0;
        end else if (btn_s2_reg == btn_stable_reg) begin
            db_cnt_reg <= '0;
        end else if (db_cnt_reg == DB_W'(DEBOUNCE - 1)) begin
            db_cnt_reg     <= '0;
            btn_stable_reg <= btn_s2_reg;
            if (btn_s2_reg) begin
                input_optical <= !input_optical;
            end
        end else begin
            db_cnt_reg <= db_cnt_reg + 1'b1;
        end
    end
endmodule : matrix_mixer_router
`default_nettype wire

/* logic/mixer_pkg.sv */
// shared constants and carriers for the matrix mixer
package mixer_pkg;
    localparam int NUM_CH          = 64;
    localparam int NUM_SRC         = 2 * NUM_CH;
    localparam int SAMPLE_W        = 24;
    localparam int GAIN_W          = 16;
    localparam int GAIN_FRAC       = 15;
    localparam int ACC_W           = 48;
    localparam int FIFO_DEPTH      = 32;
    localparam int RMS_SHIFT       = 10;
    localparam int DEBOUNCE_US     = 5000;
    localparam int CLK_MHZ         = 40;
    localparam int DEBOUNCE_CYC    = DEBOUNCE_US * CLK_MHZ;
    localparam logic [GAIN_W-1:0] GAIN_MUTE  = 16'h0000;
    localparam logic [GAIN_W-1:0] GAIN_UNITY = 16'h8000;

    typedef struct packed {
        logic [5:0]          chan;
        logic [SAMPLE_W-1:0] data;
    } sample_t;

    typedef struct packed {
        logic [6:0]        src;
        logic [5:0]        dst;
        logic [GAIN_W-1:0] gain;
    } route_wr_t;

    typedef struct packed {
        logic [5:0]        dst;
        logic [GAIN_W-1:0] gain;
    } out_wr_t;
endpackage : mixer_pkg

/* logic/sample_fifo.sv */
// parameterised valid/ready fifo for output samples
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
    parameter int WIDTH = 30,
    parameter int DEPTH = 32
) (
    input  wire logic             mclk,
    input  wire logic             resetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr_reg];

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : sample_fifo
`default_nettype wire
